// ### pkg/dwc_params.svh
// Purpose: constants of the dma write command handler
// Assumes: 125 MHz core clock on both ends
// Notes:   included by bare name
`ifndef DWC_PARAMS_SVH
`define DWC_PARAMS_SVH
`define DWC_CLK_NS      8
// task-file register select codes
`define DWC_DA_DATA     4'h0
`define DWC_DA_FEAT     4'h1
`define DWC_DA_CNT      4'h2
`define DWC_DA_LO       4'h3
`define DWC_DA_MID      4'h4
`define DWC_DA_HI       4'h5
`define DWC_DA_DEV      4'h6
`define DWC_DA_CMD      4'h7
`define DWC_DA_CTRL     4'h8
// command codes
`define DWC_CMD_DMA_A   8'hCA
`define DWC_CMD_DMA_B   8'hCB
`define DWC_CMD_DMA_EXT 8'h35
`define DWC_CMD_NCQ_WR  8'h61
`define DWC_CMD_SETF    8'hEF
`define DWC_SF_8BIT_ON  8'h01
`define DWC_SF_8BIT_OFF 8'h81
// bit positions, the hob mask and the last word index of a sector
`define DWC_ST_BSY      7
`define DWC_ST_DRDY     6
`define DWC_ST_DRQ      3
`define DWC_ST_ERR      0
`define DWC_ER_MEDIA    6
`define DWC_ER_ABRT     2
`define DWC_HOB_BIT     7
`define DWC_FUA_BIT     7
`define DWC_HOB_SET     8'h80
`define DWC_WORD_LAST   8'hFF
// host strobe timing
`define DWC_STRB_NS     80
`define DWC_RECOV_NS    80
`define DWC_STRB_CYC    ((`DWC_STRB_NS + `DWC_CLK_NS - 1) / `DWC_CLK_NS)
`define DWC_RECOV_CYC   ((`DWC_RECOV_NS + `DWC_CLK_NS - 1) / `DWC_CLK_NS)
// host apb register offsets
`define DWC_A_CTRL      8'h00
`define DWC_A_CMD       8'h04
`define DWC_A_LBA_LO    8'h08
`define DWC_A_LBA_HI    8'h0C
`define DWC_A_COUNT     8'h10
`define DWC_A_FEAT      8'h14
`define DWC_A_DEVH      8'h18
`define DWC_A_SEED      8'h1C
`define DWC_A_STATUS    8'h20
`define DWC_A_RES_LO    8'h24
`define DWC_A_RES_HI    8'h28
`endif

// ### pkg/dwc_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   count decode is common to device and host
package dwc_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_PREP = 3'h1, DS_XFER = 3'h3, DS_FLUSH = 3'h2, DS_DONE = 3'h6
  } dwc_dstate_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_SETUP = 3'h1, HS_STRB = 3'h3, HS_RECOV = 3'h2, HS_DMA = 3'h6
  } dwc_hstate_t;
  typedef struct packed {
    dwc_dstate_t st;
    logic wr_q, rd_q;
    logic [7:0] feat_c, feat_p, cnt_c, cnt_p, lo_c, lo_p, mid_c, mid_p, hi_c, hi_p, dev;
    logic hob, bsy, drq, err, abrt, merr, eight, intrq, dmarq, dd_oe;
    logic [15:0] dd;
    logic [47:0] lba;
    logic [16:0] left;
    logic [7:0]  wcnt;
    logic ext, fua;
    logic [4:0]  tag;
    logic mvalid, cap_done, flush;
    logic [15:0] mdata;
  } dwc_dev_t;
  typedef struct packed {
    dwc_hstate_t st;
    logic [4:0]  step;
    logic [3:0]  tmr;
    logic dma, indma, oe, wr_n, rd_n, ack_n, busy, done, pready, pslverr;
    logic [3:0]  da;
    logic [15:0] dd, pat, cnt, feat, seed;
    logic [24:0] words;
    logic [7:0]  cmd, devh, res_st, res_er, res_dev;
    logic [47:0] lba, res_lba;
    logic [31:0] prdata;
  } dwc_host_t;
  typedef struct packed {
    logic       rd;
    logic [3:0] da;
  } dwc_step_t;
  // zero count means the largest transfer of its width
  function automatic logic [16:0] dwc_cnt_f(input logic [15:0] v, input logic wide);
    logic [16:0] c;
    c = 17'h00000;
    if (wide) c = (v == 16'h0000) ? 17'h10000 : {1'b0, v};
    else      c = (v[7:0] == 8'h00) ? 17'h00100 : {9'h000, v[7:0]};
    return c;
  endfunction
endpackage

// ### pkg/dwc_if.sv
// Purpose: parallel task-file and dma pins between host and device
// Assumes: both ends on clock_i
// Notes:   data bus level resolved here from the two enables
interface dwc_if;
  logic [3:0]  da;
  logic        diow_n, dior_n, dmack_n, dmarq, intrq;
  logic [15:0] dd_h_o, dd_d_o, dd;
  logic        dd_h_oe, dd_d_oe;
  // host wins a clash; an undriven bus reads zero
  assign dd = dd_h_oe ? dd_h_o : (dd_d_oe ? dd_d_o : 16'h0000);
  modport dev  (input da, diow_n, dior_n, dmack_n, dd, output dd_d_o, dd_d_oe, dmarq, intrq);
  modport host (input dmarq, intrq, dd, output da, diow_n, dior_n, dmack_n, dd_h_o, dd_h_oe);
endinterface

// ### core/dwc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: RST gives the idle level of each bit
// Notes:   only the second stage leaves this module
module dwc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2;} dwc_sync_t;
  dwc_sync_t r, n;
  // shift by one stage per clock
  always_comb begin
    n = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) r <= {RST, RST};
    else       r <= n;
  end
  assign q_o = r.s2;
endmodule

// ### core/dwc_dev.sv
// Purpose: device end, task file and dma write command execution
// Assumes: host holds data and address through strobe and recovery
// Notes:   one word of holding; dmarq drops while it is occupied
// Overview of operation
// R1: codes CAh/CBh write 1..256 sectors
// R2: 28-bit count zero means 256 sectors
// R3: start at address from task-file fields
// R4: set busy, then drq and clear busy
// R5: dmarq high while a word is accepted
// R6: host strobes once per word under dmack
// R7: host sends 512 bytes per sector
// R8: interrupt only at end or error
// R9: 28-bit end leaves last sector address
// R10: error stops at failing sector, reports it
// R11: 8-bit mode aborts 28-bit dma write
// R12: code 35h writes 1..65536 sectors
// R13: 48-bit count zero means 65536
// R14: first write upper byte, second lower
// R15: 48-bit end leaves last sector lba
// R16: 48-bit error reports failing sector lba
// R17: 8-bit mode aborts 48-bit dma write
// R18: queued write 61h moves host data in
// R19: fua set flushes media before completion
// R20: fua clear completes without flush
// R21: queued: count holds tag, features sectors
// R22: host sets hob before upper-byte access
// R23: both 28-bit codes handled the same
// R24: queue tag is five upper count bits
`include "dwc_params.svh"
module dwc_dev (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  dwc_if.dev               link,
  output logic             media_valid_o,
  output logic [15:0]      media_data_o,
  output logic [47:0]      media_lba_o,
  input  wire logic        media_ready_i,
  input  wire logic        media_err_i,
  output logic             media_flush_o,
  input  wire logic        media_flush_done_i,
  output logic [4:0]       tag_o,
  output logic             fua_o
);
  localparam logic [22:0] SYNC_RST = {4'h0, 3'h7, 16'h0000};
  dwc_pkg::dwc_dev_t r, n;
  logic [22:0] sq;
  logic [3:0]  s_da;
  logic [15:0] s_dd;
  logic        s_wr, s_rd, s_ack, wr_rise, rd_rise;
  logic [7:0]  stat, errb;

  // every pin input goes through two flops first
  dwc_sync #(.W(23), .RST(SYNC_RST)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({link.da, link.diow_n, link.dior_n, link.dmack_n, link.dd}),
    .q_o     (sq)
  );
  assign s_da = sq[22:19];
  assign s_wr = !sq[18];
  assign s_rd = !sq[17];
  assign s_ack = !sq[16];
  assign s_dd = sq[15:0];
  // write strobes act on their trailing edge, when data has long settled; read strobes act on their leading edge
  assign wr_rise = r.wr_q && !s_wr;
  assign rd_rise = s_rd && !r.rd_q;

  // status and error bytes as the host reads them
  always_comb begin
    stat = 8'h00;
    stat[`DWC_ST_BSY] = r.bsy;
    stat[`DWC_ST_DRDY] = 1'b1;
    stat[`DWC_ST_DRQ] = r.drq;
    stat[`DWC_ST_ERR] = r.err;
    errb = 8'h00;
    errb[`DWC_ER_ABRT] = r.abrt;
    errb[`DWC_ER_MEDIA] = r.merr;
  end

  always_comb begin
    n = r;
    n.wr_q = s_wr;
    n.rd_q = s_rd;
    // register reads; hob picks the earlier written byte
    n.dd_oe = s_rd && !s_ack;
    if (rd_rise && !s_ack) begin
      case (s_da)
        `DWC_DA_FEAT: n.dd = {8'h00, errb};
        `DWC_DA_CNT:  n.dd = {8'h00, r.hob ? r.cnt_p : r.cnt_c};
        `DWC_DA_LO:   n.dd = {8'h00, r.hob ? r.lo_p : r.lo_c};
        `DWC_DA_MID:  n.dd = {8'h00, r.hob ? r.mid_p : r.mid_c};
        `DWC_DA_HI:   n.dd = {8'h00, r.hob ? r.hi_p : r.hi_c};
        `DWC_DA_DEV:  n.dd = {8'h00, r.dev};
        `DWC_DA_CMD,
        `DWC_DA_CTRL: n.dd = {8'h00, stat};
        default:      n.dd = 16'h0000;
      endcase
      if (s_da == `DWC_DA_CMD) n.intrq = 1'b0;
      if (s_da != `DWC_DA_CTRL) n.hob = 1'b0;
    end
    // register writes; busy refuses all but device control
    if (wr_rise && !s_ack) begin
      if (s_da == `DWC_DA_CTRL) begin
        n.hob = s_dd[`DWC_HOB_BIT];
      end else if (!r.bsy && r.st == dwc_pkg::DS_IDLE) begin
        n.hob = 1'b0;
        case (s_da)
          `DWC_DA_FEAT: begin n.feat_p = r.feat_c; n.feat_c = s_dd[7:0]; end // [R14]
          `DWC_DA_CNT:  begin n.cnt_p = r.cnt_c; n.cnt_c = s_dd[7:0]; end // [R14]
          `DWC_DA_LO:   begin n.lo_p = r.lo_c; n.lo_c = s_dd[7:0]; end // [R14]
          `DWC_DA_MID:  begin n.mid_p = r.mid_c; n.mid_c = s_dd[7:0]; end // [R14]
          `DWC_DA_HI:   begin n.hi_p = r.hi_c; n.hi_c = s_dd[7:0]; end // [R14]
          `DWC_DA_DEV:  n.dev = s_dd[7:0];
          `DWC_DA_CMD: begin
            n.err = 1'b0;
            n.abrt = 1'b0;
            n.merr = 1'b0;
            n.fua = 1'b0;
            n.wcnt = 8'h00;
            n.cap_done = 1'b0;
            n.lba = {r.hi_p, r.mid_p, r.lo_p, r.hi_c, r.mid_c, r.lo_c};
            case (s_dd[7:0])
              `DWC_CMD_DMA_A,
              `DWC_CMD_DMA_B: begin // [R23]
                n.ext = 1'b0;
                n.lba = {20'h00000, r.dev[3:0], r.hi_c, r.mid_c, r.lo_c}; // [R3]
                n.left = dwc_pkg::dwc_cnt_f({8'h00, r.cnt_c}, 1'b0); // [R1] [R2]
                if (r.eight) n.abrt = 1'b1; // [R11]
                else n.st = dwc_pkg::DS_PREP;
              end
              `DWC_CMD_DMA_EXT: begin
                n.ext = 1'b1;
                n.left = dwc_pkg::dwc_cnt_f({r.cnt_p, r.cnt_c}, 1'b1); // [R12] [R13]
                if (r.eight) n.abrt = 1'b1; // [R17]
                else n.st = dwc_pkg::DS_PREP;
              end
              `DWC_CMD_NCQ_WR: begin // [R18]
                n.ext = 1'b1;
                n.left = dwc_pkg::dwc_cnt_f({r.feat_p, r.feat_c}, 1'b1); // [R21]
                n.tag = r.cnt_c[7:3]; // [R24]
                n.fua = r.dev[`DWC_FUA_BIT];
                n.st = dwc_pkg::DS_PREP;
              end
              `DWC_CMD_SETF: begin
                if (r.feat_c == `DWC_SF_8BIT_ON) n.eight = 1'b1;
                else if (r.feat_c == `DWC_SF_8BIT_OFF) n.eight = 1'b0;
                else n.abrt = 1'b1;
                n.intrq = 1'b1;
              end
              default: n.abrt = 1'b1;
            endcase
            // an abort completes at once with an interrupt
            if (n.abrt) begin
              n.err = 1'b1;
              n.intrq = 1'b1;
            end
            if (n.st == dwc_pkg::DS_PREP) begin
              n.bsy = 1'b1; // [R4]
              n.intrq = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    // dma data word from the host into the holding register
    if (wr_rise && s_ack && r.st == dwc_pkg::DS_XFER && r.dmarq && !r.mvalid) begin // [R6]
      n.mvalid = 1'b1;
      n.mdata = s_dd;
      if (r.left == 17'h00001 && r.wcnt == `DWC_WORD_LAST) n.cap_done = 1'b1; // [R7]
    end
    // media takes the word; a sector ends on its 256th word
    if (r.mvalid && media_ready_i) begin
      n.mvalid = 1'b0;
      if (r.wcnt == `DWC_WORD_LAST) begin
        n.wcnt = 8'h00;
        if (media_err_i) begin
          n.err = 1'b1; // [R10] [R16]
          n.merr = 1'b1;
          n.cap_done = 1'b1;
          n.st = dwc_pkg::DS_DONE;
        end else if (r.left == 17'h00001) begin
          n.flush = r.fua; // [R19] [R20]
          n.st = r.fua ? dwc_pkg::DS_FLUSH : dwc_pkg::DS_DONE;
        end else begin
          n.lba = r.lba + 48'h000000000001;
          n.left = r.left - 17'h00001;
        end
      end else begin
        n.wcnt = r.wcnt + 8'h01;
      end
    end
    // command sequencing
    case (r.st)
      dwc_pkg::DS_IDLE: ;
      dwc_pkg::DS_PREP: begin
        n.bsy = 1'b0; // [R4]
        n.drq = 1'b1;
        n.st = dwc_pkg::DS_XFER;
      end
      dwc_pkg::DS_XFER: ;
      dwc_pkg::DS_FLUSH: begin
        n.bsy = 1'b1;
        n.drq = 1'b0;
        if (media_flush_done_i) begin
          n.flush = 1'b0;
          n.st = dwc_pkg::DS_DONE;
        end
      end
      dwc_pkg::DS_DONE: begin
        n.lo_c = r.lba[7:0]; // [R9] [R10] [R15] [R16]
        n.mid_c = r.lba[15:8];
        n.hi_c = r.lba[23:16];
        if (r.ext) begin
          n.lo_p = r.lba[31:24];
          n.mid_p = r.lba[39:32];
          n.hi_p = r.lba[47:40];
        end else begin
          n.dev = {r.dev[7:4], r.lba[27:24]};
        end
        n.bsy = 1'b0;
        n.drq = 1'b0;
        n.intrq = 1'b1; // [R8]
        n.st = dwc_pkg::DS_IDLE;
      end
      default: n.st = dwc_pkg::DS_IDLE;
    endcase
    // request data only while the holding register is free
    n.dmarq = (n.st == dwc_pkg::DS_XFER) && !n.mvalid && !n.cap_done; // [R5]
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) r <= '0;
    else       r <= n;
  end

  assign link.dd_d_o = r.dd;
  assign link.dd_d_oe = r.dd_oe;
  assign link.dmarq = r.dmarq;
  assign link.intrq = r.intrq;
  assign media_valid_o = r.mvalid;
  assign media_data_o = r.mdata;
  assign media_lba_o = r.lba;
  assign media_flush_o = r.flush;
  assign tag_o = r.tag;
  assign fua_o = r.fua;
endmodule

// ### core/dwc_host.sv
// Purpose: host end, apb-programmed command issue and dma data pump
// Assumes: software waits for done before the next start
// Notes:   data words are a counting pattern from the seed register
//
// The APB slave port and the register addresses were left to the implementer.
`include "dwc_params.svh"
module dwc_host (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  dwc_if.host              link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  localparam logic [3:0] STRB_C = 4'(`DWC_STRB_CYC);
  localparam logic [3:0] RECOV_C = 4'(`DWC_RECOV_CYC);
  dwc_pkg::dwc_host_t r, n;
  dwc_pkg::dwc_step_t stp;
  logic [17:0] sq;
  logic        s_rq, s_int;
  logic [15:0] s_dd;
  logic [7:0]  wbyte;

  // pin inputs through two flops
  dwc_sync #(.W(18), .RST(18'h00000)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({link.dmarq, link.intrq, link.dd}),
    .q_o     (sq)
  );
  assign s_rq = sq[17];
  assign s_int = sq[16];
  assign s_dd = sq[15:0];

  // fixed access sequence: load task file, then read back results
  function automatic dwc_pkg::dwc_step_t step_f(input logic [4:0] i);
    dwc_pkg::dwc_step_t s;
    s.rd = (i >= 5'd12) && (i != 5'd18) && (i != 5'd20) && (i != 5'd22);
    case (i)
      5'd0, 5'd1, 5'd13:   s.da = `DWC_DA_FEAT;
      5'd2, 5'd3:          s.da = `DWC_DA_CNT;
      5'd4, 5'd5, 5'd14, 5'd19: s.da = `DWC_DA_LO;
      5'd6, 5'd7, 5'd15, 5'd21: s.da = `DWC_DA_MID;
      5'd8, 5'd9, 5'd16, 5'd23: s.da = `DWC_DA_HI;
      5'd10, 5'd17:        s.da = `DWC_DA_DEV;
      5'd11, 5'd12:        s.da = `DWC_DA_CMD;
      default:             s.da = `DWC_DA_CTRL;
    endcase
    return s;
  endfunction
  assign stp = step_f(r.step);

  // byte written at each step: upper byte first, then lower [R14]
  always_comb begin
    case (r.step)
      5'd0:    wbyte = r.feat[15:8];
      5'd1:    wbyte = r.feat[7:0];
      5'd2:    wbyte = r.cnt[15:8];
      5'd3:    wbyte = r.cnt[7:0];
      5'd4:    wbyte = r.lba[31:24];
      5'd5:    wbyte = r.lba[7:0];
      5'd6:    wbyte = r.lba[39:32];
      5'd7:    wbyte = r.lba[15:8];
      5'd8:    wbyte = r.lba[47:40];
      5'd9:    wbyte = r.lba[23:16];
      5'd10:   wbyte = r.devh;
      5'd11:   wbyte = r.cmd;
      default: wbyte = `DWC_HOB_SET; // upper half readable only after hob [R22]
    endcase
  end

  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // apb: answer in the first access cycle
    if (psel_i && !penable_i) begin
      n.pready = 1'b1;
      case (paddr_i)
        `DWC_A_CTRL:   n.prdata = {30'h00000000, r.dma, 1'b0};
        `DWC_A_CMD:    n.prdata = {24'h000000, r.cmd};
        `DWC_A_LBA_LO: n.prdata = r.lba[31:0];
        `DWC_A_LBA_HI: n.prdata = {16'h0000, r.lba[47:32]};
        `DWC_A_COUNT:  n.prdata = {16'h0000, r.cnt};
        `DWC_A_FEAT:   n.prdata = {16'h0000, r.feat};
        `DWC_A_DEVH:   n.prdata = {24'h000000, r.devh};
        `DWC_A_SEED:   n.prdata = {16'h0000, r.seed};
        `DWC_A_STATUS: n.prdata = {r.res_dev, r.res_er, r.res_st, 6'h00, r.done, r.busy};
        `DWC_A_RES_LO: n.prdata = r.res_lba[31:0];
        `DWC_A_RES_HI: n.prdata = {16'h0000, r.res_lba[47:32]};
        default: begin
          n.prdata = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (psel_i && penable_i && pwrite_i && r.pready && !r.pslverr) begin
      case (paddr_i)
        `DWC_A_CTRL: begin
          n.dma = pwdata_i[1];
          if (pwdata_i[0] && !r.busy) begin
            n.busy = 1'b1;
            n.done = 1'b0;
            n.step = 5'd0;
            n.pat = r.seed;
            n.words = pwdata_i[1] ? {dwc_pkg::dwc_cnt_f(
                (r.cmd == `DWC_CMD_NCQ_WR) ? r.feat : r.cnt, // [R21]
                r.cmd == `DWC_CMD_DMA_EXT || r.cmd == `DWC_CMD_NCQ_WR), 8'h00} : 25'h0000000;
            n.st = dwc_pkg::HS_SETUP;
          end
        end
        `DWC_A_CMD:    n.cmd = pwdata_i[7:0];
        `DWC_A_LBA_LO: n.lba[31:0] = pwdata_i;
        `DWC_A_LBA_HI: n.lba[47:32] = pwdata_i[15:0];
        `DWC_A_COUNT:  n.cnt = pwdata_i[15:0];
        `DWC_A_FEAT:   n.feat = pwdata_i[15:0];
        `DWC_A_DEVH:   n.devh = pwdata_i[7:0];
        `DWC_A_SEED:   n.seed = pwdata_i[15:0];
        default: ;
      endcase
    end
    // pin sequencing
    case (r.st)
      dwc_pkg::HS_IDLE: ;
      dwc_pkg::HS_SETUP: begin
        n.da = stp.da;
        n.dd = {8'h00, wbyte};
        n.oe = !stp.rd;
        n.rd_n = !stp.rd;
        n.wr_n = stp.rd;
        n.tmr = STRB_C;
        n.st = dwc_pkg::HS_STRB;
      end
      dwc_pkg::HS_STRB: begin
        n.tmr = r.tmr - 4'h1;
        if (r.tmr == 4'h1) begin
          n.wr_n = 1'b1;
          n.rd_n = 1'b1;
          n.tmr = RECOV_C;
          n.st = dwc_pkg::HS_RECOV;
          if (r.indma) begin
            n.words = r.words - 25'h0000001;
            n.pat = r.pat + 16'h0001;
          end
          if (!r.rd_n) begin
            case (r.step)
              5'd12:   n.res_st = s_dd[7:0];
              5'd13:   n.res_er = s_dd[7:0];
              5'd14:   n.res_lba[7:0] = s_dd[7:0];
              5'd15:   n.res_lba[15:8] = s_dd[7:0];
              5'd16:   n.res_lba[23:16] = s_dd[7:0];
              5'd17:   n.res_dev = s_dd[7:0];
              5'd19:   n.res_lba[31:24] = s_dd[7:0];
              5'd21:   n.res_lba[39:32] = s_dd[7:0];
              default: n.res_lba[47:40] = s_dd[7:0];
            endcase
          end
        end
      end
      dwc_pkg::HS_RECOV: begin
        n.tmr = r.tmr - 4'h1;
        if (r.tmr == 4'h1) begin
          n.oe = 1'b0;
          if (r.indma || r.step == 5'd11) begin
            n.indma = 1'b1;
            n.ack_n = (r.words == 25'h0000000);
            n.st = dwc_pkg::HS_DMA;
          end else if (r.step == 5'd23) begin
            n.busy = 1'b0;
            n.done = 1'b1;
            n.st = dwc_pkg::HS_IDLE;
          end else begin
            n.step = r.step + 5'd1;
            n.st = dwc_pkg::HS_SETUP;
          end
        end
      end
      dwc_pkg::HS_DMA: begin
        // interrupt ends the data phase, even short of the count
        if (s_int) begin
          n.ack_n = 1'b1;
          n.indma = 1'b0;
          n.step = 5'd12;
          n.st = dwc_pkg::HS_SETUP;
        end else if (r.words != 25'h0000000 && s_rq) begin // [R6]
          n.da = `DWC_DA_DATA;
          n.dd = r.pat;
          n.oe = 1'b1;
          n.wr_n = 1'b0;
          n.tmr = STRB_C;
          n.st = dwc_pkg::HS_STRB;
        end
      end
      default: n.st = dwc_pkg::HS_IDLE;
    endcase
  end

  // idle strobes and dmack are high after reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.wr_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.ack_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.da = r.da;
  assign link.diow_n = r.wr_n;
  assign link.dior_n = r.rd_n;
  assign link.dmack_n = r.ack_n;
  assign link.dd_h_o = r.dd;
  assign link.dd_h_oe = r.oe;
  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
endmodule

// ### testbench/dwc_props.sv
// Purpose: pin checks on the link between host and device ends
// Assumes: one clock, reset active high
// Notes:   sees only signals of dwc_if
module dwc_props (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  da,
  input  wire logic        diow_n,
  input  wire logic        dior_n,
  input  wire logic        dmack_n,
  input  wire logic        dmarq,
  input  wire logic        intrq,
  input  wire logic [15:0] dd,
  input  wire logic        dd_h_oe,
  input  wire logic        dd_d_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // a strobe must outlast both synchronisers or the word is lost
  sequence s_low;
    !diow_n [*8];
  endsequence
  strobe_len_a: assert property ($fell(diow_n) |-> s_low)
    else $error("write strobe too short");
  strobe_end_a: assert property ($fell(diow_n) |-> ##[1:12] diow_n)
    else $error("write strobe stuck low");
  data_hold_a: assert property (!diow_n ##1 !diow_n |-> $stable(dd) && dd_h_oe)
    else $error("data moved in strobe");
  bus_clash_a: assert property (!(dd_h_oe && dd_d_oe))
    else $error("both ends drive data");
  dma_ack_a: assert property (!diow_n && da == 4'h0 |-> !dmack_n)
    else $error("data word without ack");
  no_midirq_a: assert property (dmarq |-> !intrq)
    else $error("interrupt while requesting");
  irq_clear_a: assert property ($fell(intrq) |-> da == 4'h7 && !dior_n)
    else $error("interrupt dropped unread");
  dev_drive_a: assert property ($rose(dd_d_oe) |-> !dior_n)
    else $error("device drives unasked");
endmodule

// ### testbench/dma_write_command_handler_tb.sv
// Purpose: runs dma write commands from apb down to the media port
// Assumes: media always ready; flush answered one cycle late
// Notes:   counts of zero are not run, they would take too long
`include "dwc_params.svh"
module dma_write_command_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        m_err = 1'b0, f_done = 1'b0, saw_flush = 1'b0;
  logic        pready, pslverr, m_valid, m_flush, fua;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] m_data, seed = 16'h0;
  logic [47:0] m_lba, lba0;
  logic [4:0]  tag;
  int          n_fail = 0, n_tests = 0, nw = 0;
  dwc_if dwc_if_inst ();
  dwc_host dwc_host_inst (.clock_i(clock_i), .rst_i(rst_i), .link(dwc_if_inst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  dwc_dev dwc_dev_inst (.clock_i(clock_i), .rst_i(rst_i), .link(dwc_if_inst),
    .media_valid_o(m_valid), .media_data_o(m_data), .media_lba_o(m_lba),
    .media_ready_i(1'b1), .media_err_i(m_err), .media_flush_o(m_flush),
    .media_flush_done_i(f_done), .tag_o(tag), .fua_o(fua));
  dwc_props dwc_props_inst (.clock_i(clock_i), .rst_i(rst_i), .da(dwc_if_inst.da),
    .diow_n(dwc_if_inst.diow_n), .dior_n(dwc_if_inst.dior_n),
    .dmack_n(dwc_if_inst.dmack_n), .dmarq(dwc_if_inst.dmarq), .intrq(dwc_if_inst.intrq),
    .dd(dwc_if_inst.dd), .dd_h_oe(dwc_if_inst.dd_h_oe), .dd_d_oe(dwc_if_inst.dd_d_oe));
  always #4 clock_i = ~clock_i;
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    n_tests++;
    if (e !== s) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // media side: every word must follow the seed pattern
  always @(posedge clock_i) begin
    f_done <= m_flush;
    if (m_flush) saw_flush <= 1'b1;
    if (m_valid) begin
      chk("media word", 48'(seed + nw[15:0]), 48'(m_data));
      chk("media lba", lba0 + 48'(nw / 256), m_lba);
      nw <= nw + 1;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // program one command, start it, poll for done, fetch the result address
  task automatic run(input logic [7:0] c, input logic [47:0] l, input logic [15:0] n, f,
                     input logic [7:0] dh, input logic [1:0] ctl,
                     output logic [31:0] st, output logic [47:0] res);
    logic [31:0] r, h;
    int i;
    nw = 0;
    lba0 = l;
    apb(1'b1, `DWC_A_CMD, {24'h0, c}, r);
    apb(1'b1, `DWC_A_LBA_LO, l[31:0], r);
    apb(1'b1, `DWC_A_LBA_HI, {16'h0, l[47:32]}, r);
    apb(1'b1, `DWC_A_COUNT, {16'h0, n}, r);
    apb(1'b1, `DWC_A_FEAT, {16'h0, f}, r);
    apb(1'b1, `DWC_A_DEVH, {24'h0, dh}, r);
    apb(1'b1, `DWC_A_SEED, {16'h0, seed}, r);
    apb(1'b1, `DWC_A_CTRL, {30'h0, ctl}, r);
    i = 0;
    do begin
      repeat (16) @(posedge clock_i);
      apb(1'b0, `DWC_A_STATUS, 32'h0, st);
      i++;
    end while (st[1] !== 1'b1 && i < 3000);
    chk("done", 48'h1, 48'(st[1]));
    apb(1'b0, `DWC_A_RES_LO, 32'h0, r);
    apb(1'b0, `DWC_A_RES_HI, 32'h0, h);
    res = {h[15:0], r};
  endtask
  task automatic t_dma28;
    logic [31:0] st;
    logic [47:0] res;
    seed = 16'h1000;
    run(`DWC_CMD_DMA_A, 48'h5123400, 16'h0002, 16'h0000, 8'hE5, 2'h3, st, res);
    chk("error flag", 48'h0, 48'(st[8]));
    chk("words", 48'h200, 48'(nw));
    chk("last lba", 48'h5123401, {20'h0, st[27:24], res[23:0]});
  endtask
  task automatic t_err28;
    logic [31:0] st;
    logic [47:0] res;
    seed = 16'h2000;
    m_err <= 1'b1;
    run(`DWC_CMD_DMA_B, 48'h0000200, 16'h0002, 16'h0000, 8'hE0, 2'h3, st, res);
    m_err <= 1'b0;
    chk("media error", 48'h1, 48'(st[22]));
    chk("failing lba", 48'h200, 48'(res[23:0]));
    chk("words", 48'h100, 48'(nw));
  endtask
  task automatic t_ext;
    logic [31:0] st;
    logic [47:0] res;
    seed = 16'h3000;
    run(`DWC_CMD_DMA_EXT, 48'hA1B2C3D4E5F0, 16'h0001, 16'h0000, 8'hE0, 2'h3, st, res);
    chk("error flag", 48'h0, 48'(st[8]));
    chk("last lba", 48'hA1B2C3D4E5F0, res);
  endtask
  task automatic t_ncq;
    logic [31:0] st;
    logic [47:0] res;
    seed = 16'h4000;
    saw_flush = 1'b0;
    run(`DWC_CMD_NCQ_WR, 48'h1000, 16'h0028, 16'h0001, 8'hC0, 2'h3, st, res);
    chk("tag", 48'h5, 48'(tag));
    chk("fua", 48'h1, 48'(fua));
    chk("flush", 48'h1, 48'(saw_flush));
    chk("words", 48'h100, 48'(nw));
    chk("last lba", 48'h1000, res);
  endtask
  // 8-bit mode on must abort both dma write widths
  task automatic t_abort;
    logic [31:0] st;
    logic [47:0] res;
    logic [7:0] c [2];
    c = '{`DWC_CMD_DMA_A, `DWC_CMD_DMA_EXT};
    foreach (c[i]) begin
      run(`DWC_CMD_SETF, 48'h0, 16'h0, 16'h0001, 8'hE0, 2'h1, st, res);
      run(c[i], 48'h10, 16'h0001, 16'h0000, 8'hE0, 2'h3, st, res);
      chk("abort", 48'h1, 48'(st[18]));
      chk("words", 48'h0, 48'(nw));
      run(`DWC_CMD_SETF, 48'h0, 16'h0, 16'h0081, 8'hE0, 2'h1, st, res);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    t_dma28();
    t_err28();
    t_ext();
    t_ncq();
    t_abort();
    test_done();
  end
  // watchdog well beyond the five scenarios
  initial begin
    repeat (95000) @(posedge clock_i);
    n_fail++;
    test_done();
  end
endmodule
